// ### core/sac_twowire_slave.sv
// Two-wire slave front end and conversion sequencing of a 16-bit converter.
// Assumes open-drain bus lines resolved outside; conversion clock free-running.
//
// Contract
// - Power-on reset leaves the device shut down.
// - Sampler tracks only during the two bus clocks before conversion.
// - Conversion is timed by the internal oscillator, not the bus clock.
// - Clock line is held low while a conversion runs.
// - Master reads the result after clock release at up to 1.7 MHz.
// - One bit per clock; each byte plus acknowledge takes nine clocks.
// - Data changes only with clock low; changes with clock high are start/stop.
// - Idle bus rests with both lines high.
// - Stop releases bus and returns to slow timing; repeated start keeps mode.
// - Acknowledge is data low through the ninth clock high; release is not-acknowledge.
// - Seven-bit address 011 plus four select inputs, then a read/write bit.
// - Idle device waits for start plus own address, then begins acquiring.
// - External reference ignores read/write; internal with 0 shuts reference after.
// - Device acknowledges its address for one clock, then starts converting.
// - Power-up bus timing is the slow mode; high speed needs the master code.
// - Master code 00001xxx is not-acknowledged and switches to high speed.
// - Result goes out high byte first, then low byte.
// - Master acknowledge keeps converting; not-acknowledge frees the bus.
// - Continuous mode gives one sample per eighteen clocks plus conversion.
// - Analog part powers on a valid address and off after conversion.
// - Internal reference with bit 0 shuts down on master not-acknowledge.
// - Reference starts up on ninth falling edge; settles twelve milliseconds.
`timescale 1ns/100ps
module sac_twowire_slave #(
  parameter int unsigned REF_SETTLE_CYC = sac_pkg::REF_SETTLE_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_conv,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_bit_zero,
  input wire logic address_select_bit_one,
  input wire logic address_select_bit_two,
  input wire logic address_select_bit_three,
  input wire logic reference_adjust_pin,
  input wire logic cmp_in,
  output logic [15:0] dac_code,
  output logic track,
  output logic analog_power,
  output logic ref_power,
  output logic ref_ready,
  output logic hs_mode,
  output logic conv_busy,
  output sac_pkg::sac_state_t bus_state
);
  import sac_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [PIN_W-1:0] raw, s1, s2, s3, filt;
  sac_pins_t pins;
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, ev_start, ev_stop;
  sac_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [15:0] txreg;
  logic [15:0] result;
  logic byte_sel;
  logic ack_seen;
  logic rw;
  logic start_tgl;
  logic done_tgl;
  logic d1, d2, d3;
  logic done_pulse;
  logic ev_match7, ev_addr_ok, ev_conv_go, ev_nack_rd;
  logic [REF_CNT_W-1:0] ref_cnt;
  logic internal_ref;

  // True when the seven received bits name this device
  function automatic logic addr_match(input logic [6:0] a, input logic [3:0] sel);
    addr_match = (a == {ADDR_FIXED, sel});
  endfunction : addr_match

  // True for the high-speed master code in the upper five bits
  function automatic logic hs_code_seen(input logic [4:0] a);
    hs_code_seen = (a == HS_CODE);
  endfunction : hs_code_seen

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and glitch rejection

  assign raw = {scl_in, sda_in, reference_adjust_pin,
                address_select_bit_three, address_select_bit_two,
                address_select_bit_one, address_select_bit_zero};

  // Three flops; the first one is read by the second only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1 <= PINS_IDLE;
      s2 <= PINS_IDLE;
      s3 <= PINS_IDLE;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A level counts only once two stages agree, so a one-cycle spike is lost
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_filt
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          filt[gi] <= PINS_IDLE[gi];
        end else if (s2[gi] == s3[gi]) begin
          filt[gi] <= s3[gi];
        end
      end
    end
  endgenerate

  assign pins = sac_pins_t'(filt);
  assign internal_ref = ~pins.ref_ext;

  ////////////////////////////////////////////////////////////////////////////
  // Bus events

  // Previous filtered levels for edge detection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= pins.scl;
      sda_q <= pins.sda;
    end
  end

  // Data moving with clock high is a control event, never a bit
  assign scl_rise = pins.scl & ~scl_q;
  assign scl_fall = ~pins.scl & scl_q;
  assign ev_start = pins.scl & scl_q & sda_q & ~pins.sda;
  assign ev_stop = pins.scl & scl_q & ~sda_q & pins.sda;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion-done crossing

  // Toggle back from the oscillator domain; d1 feeds d2 only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      d1 <= 1'b0;
      d2 <= 1'b0;
      d3 <= 1'b0;
    end else begin
      d1 <= done_tgl;
      d2 <= d1;
      d3 <= d2;
    end
  end

  assign done_pulse = d2 ^ d3;

  ////////////////////////////////////////////////////////////////////////////
  // Strobes shared by the power logic

  assign ev_match7 = (state == ST_ADDR) && scl_fall && (bitcnt == LAST_DATA_BIT) &&
                     addr_match(shreg[6:0], pins.addr_sel);
  assign ev_addr_ok = (state == ST_ADDR_ACK) && scl_fall;
  assign ev_conv_go = ev_addr_ok ||
                      ((state == ST_TX_ACK) && scl_fall && ack_seen && byte_sel);
  assign ev_nack_rd = (state == ST_TX_ACK) && scl_fall && !ack_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state machine

  // Start and stop override everything; the stretch keeps the master out
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bitcnt <= '0;
      shreg <= '0;
      txreg <= '0;
      byte_sel <= 1'b0;
      ack_seen <= 1'b0;
      rw <= 1'b1;
      sda_oe <= 1'b0;
    end else if (ev_stop) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (ev_start) begin
      state <= ST_ADDR;
      bitcnt <= '0;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], pins.sda};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
            if (addr_match(shreg[7:1], pins.addr_sel)) begin
              rw <= shreg[0];
              sda_oe <= 1'b1;
              state <= ST_ADDR_ACK;
            end else if (hs_code_seen(shreg[7:3])) begin
              state <= ST_HS_NACK;
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          // Acknowledge held through the ninth clock, dropped on its fall
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (done_pulse) begin
            txreg <= result;
            sda_oe <= ~result[RES_W-1];
            bitcnt <= '0;
            byte_sel <= 1'b0;
            state <= ST_TX;
          end
        end
        ST_TX: begin
          // New bit only after the clock has gone low
          if (scl_fall) begin
            txreg <= {txreg[14:0], 1'b0};
            if (bitcnt == LAST_DATA_BIT) begin
              sda_oe <= 1'b0;
              bitcnt <= '0;
              state <= ST_TX_ACK;
            end else begin
              sda_oe <= ~txreg[RES_W-2];
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            ack_seen <= ~pins.sda;
          end else if (scl_fall) begin
            if (!ack_seen) begin
              state <= ST_IGNORE;
            end else if (!byte_sel) begin
              byte_sel <= 1'b1;
              sda_oe <= ~txreg[RES_W-1];
              state <= ST_TX;
            end else begin
              state <= ST_CONV;
            end
          end
        end
        ST_HS_NACK: begin
          // Leave data released for the ninth clock
          if (scl_fall) begin
            state <= ST_IGNORE;
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing mode

  // Only a stop drops back; a repeated start leaves the mode alone
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hs_mode <= 1'b0;
    end else if (ev_stop) begin
      hs_mode <= 1'b0;
    end else if (state == ST_HS_NACK && scl_fall) begin
      hs_mode <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock stretch and conversion launch

  // Line is held from the ninth fall until the result is in the shifter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_oe <= 1'b0;
      start_tgl <= 1'b0;
    end else if (ev_conv_go) begin
      scl_oe <= 1'b1;
      start_tgl <= ~start_tgl;
    end else if (state == ST_CONV && done_pulse) begin
      scl_oe <= 1'b0;
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign conv_busy = (state == ST_CONV);
  assign bus_state = state;

  ////////////////////////////////////////////////////////////////////////////
  // Track and hold

  // Tracks over the read bit and acknowledge, or last bit and acknowledge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      track <= 1'b0;
    end else if (ev_start || ev_stop || ev_conv_go || ev_nack_rd) begin
      track <= 1'b0;
    end else if (ev_match7) begin
      track <= 1'b1;
    end else if (state == ST_TX && byte_sel && scl_fall && bitcnt == TRACK_BIT) begin
      track <= 1'b1;
    end else if (state == ST_ADDR && scl_fall && bitcnt == BITS_PER_BYTE) begin
      track <= addr_match(shreg[7:1], pins.addr_sel);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power control

  // Analog side wakes on the address, sleeps once the result is captured
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      analog_power <= 1'b0;
    end else if (ev_match7 || ev_conv_go) begin
      analog_power <= 1'b1;
    end else if (done_pulse) begin
      analog_power <= 1'b0;
    end
  end

  // Reference wakes on the ninth fall; read/write 0 arms its shutdown
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ref_power <= 1'b0;
    end else if (!internal_ref) begin
      ref_power <= 1'b0;
    end else if (ev_addr_ok) begin
      ref_power <= 1'b1;
    end else if (ev_nack_rd && !rw) begin
      ref_power <= 1'b0;
    end
  end

  // Settling count; ref_ready rises once it ends and clears with the reference
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ref_cnt <= '0;
      ref_ready <= 1'b0;
    end else if (!ref_power) begin
      ref_cnt <= '0;
      ref_ready <= 1'b0;
    end else if (ref_cnt == REF_CNT_W'(REF_SETTLE_CYC)) begin
      ref_ready <= 1'b1;
    end else begin
      ref_cnt <= ref_cnt + REF_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter on the oscillator clock

  sac_sar_core u_sar (
    .clk_conv(clk_conv),
    .rst_n(rst_n),
    .start_tgl(start_tgl),
    .cmp_in(cmp_in),
    .dac_code(dac_code),
    .result(result),
    .done_tgl(done_tgl)
  );

endmodule : sac_twowire_slave

// ### core/sac_pkg.sv
// Shared constants and types for the two-wire converter front end.
// Assumes a 25 MHz system clock and a free-running 4 MHz conversion clock.
package sac_pkg;

  // Clock rates in their own units
  localparam int unsigned SYS_CLK_HZ = 25_000_000;
  localparam int unsigned CONV_CLK_HZ = 4_000_000;

  // Reference settling time and its cycle count at the system clock
  localparam int unsigned REF_SETTLE_MS = 12;
  localparam int unsigned REF_SETTLE_CYC_DEF =
    (REF_SETTLE_MS * (SYS_CLK_HZ / 1000));
  localparam int unsigned REF_CNT_W = 19;

  // Address layout: fixed upper bits, high-speed master code
  localparam logic [2:0] ADDR_FIXED = 3'h3;
  localparam logic [4:0] HS_CODE = 5'h01;

  // Byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] TRACK_BIT = 4'h6;
  localparam int unsigned RES_W = 16;
  localparam logic [3:0] SAR_LAST = 4'h0;
  localparam logic [3:0] SAR_FIRST = 4'hf;
  localparam logic [15:0] SAR_MSB = 16'h8000;

  // Synchronised pins
  typedef struct packed {
    logic scl;
    logic sda;
    logic ref_ext;
    logic [3:0] addr_sel;
  } sac_pins_t;
  localparam int unsigned PIN_W = 7;
  localparam sac_pins_t PINS_IDLE = 7'h60;

  // Bus protocol states, Gray along the read path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_CONV = 3'h2,
    ST_TX = 3'h6,
    ST_TX_ACK = 3'h7,
    ST_HS_NACK = 3'h5,
    ST_IGNORE = 3'h4
  } sac_state_t;

endpackage : sac_pkg

// ### core/sac_sar_core.sv
// Successive-approximation sequencer on the conversion oscillator clock.
// Assumes start_tgl is a level toggled in another domain and held between toggles.
`timescale 1ns/100ps
module sac_sar_core (
  input wire logic clk_conv,
  input wire logic rst_n,
  input wire logic start_tgl,
  input wire logic cmp_in,
  output logic [15:0] dac_code,
  output logic [15:0] result,
  output logic done_tgl
);
  import sac_pkg::*;

  logic rs1, rs2;
  logic t1, t2, t3;
  logic busy;
  logic [3:0] step;
  logic [15:0] mask;
  logic [15:0] next_code;

  // Reset level crosses by two flops
  always_ff @(posedge clk_conv) begin
    rs1 <= rst_n;
    rs2 <= rs1;
  end

  // Start toggle crossing; t1 feeds t2 only
  always_ff @(posedge clk_conv) begin
    if (!rs2) begin
      t1 <= 1'b0;
      t2 <= 1'b0;
      t3 <= 1'b0;
    end else begin
      t1 <= start_tgl;
      t2 <= t1;
      t3 <= t2;
    end
  end

  // Keep the trial bit when the comparator says input is above
  assign next_code = (cmp_in ? dac_code : (dac_code & ~mask)) | (mask >> 1);

  // Bit-per-cycle search, timed only by the oscillator
  always_ff @(posedge clk_conv) begin
    if (!rs2) begin
      busy <= 1'b0;
      step <= SAR_LAST;
      mask <= '0;
      dac_code <= '0;
      result <= '0;
      done_tgl <= 1'b0;
    end else if (!busy && (t2 ^ t3)) begin
      busy <= 1'b1;
      step <= SAR_FIRST;
      mask <= SAR_MSB;
      dac_code <= SAR_MSB;
    end else if (busy) begin
      dac_code <= next_code;
      mask <= mask >> 1;
      step <= step - 4'h1;
      if (step == SAR_LAST) begin
        busy <= 1'b0;
        result <= next_code;
        done_tgl <= ~done_tgl;
      end
    end
  end

endmodule : sac_sar_core

// ### tb/sac_twowire_slave_assertions.sv
// Concurrent checks on the converter's two-wire front end.
// Assumes bus lines resolved outside; sees only the top module's ports.
`timescale 1ns/100ps
module sac_twowire_slave_assertions #(
  parameter int unsigned REF_SETTLE_CYC = 50
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic reference_adjust_pin,
  input wire logic track,
  input wire logic analog_power,
  input wire logic ref_power,
  input wire logic ref_ready,
  input wire logic hs_mode,
  input wire logic conv_busy,
  input wire logic [2:0] bus_state
);
  import sac_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////
  // Cycles the reference has been on; saturates to stay small
  int unsigned ref_cnt;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !ref_power) begin
      ref_cnt <= 0;
    end else if (ref_cnt < REF_SETTLE_CYC + 8) begin
      ref_cnt <= ref_cnt + 1;
    end
  end
  // Clock rises seen while tracking; a one-clock window would show only one
  logic [1:0] trk_rises;
  logic scl_d;
  always_ff @(posedge clk_sys) begin
    scl_d <= scl_in;
    if (!rst_n || !track) begin
      trk_rises <= '0;
    end else if (scl_in && !scl_d && trk_rises != 2'h3) begin
      trk_rises <= trk_rises + 2'h1;
    end
  end
  ////////////////////////
  // Properties, one per rule
  property p_stretch;
    conv_busy && $past(conv_busy) |-> scl_oe;
  endproperty
  property p_hold;
    conv_busy && $past(conv_busy) |-> !track;
  endproperty
  property p_power;
    $rose(conv_busy) |-> analog_power;
  endproperty
  property p_release;
    $fell(scl_oe) |-> bus_state == ST_TX;
  endproperty
  property p_data_low;
    $changed(sda_oe) |-> !$past(scl_in);
  endproperty
  property p_ack_conv;
    $fell(sda_oe) && $past(bus_state) == ST_ADDR_ACK |-> scl_oe && conv_busy;
  endproperty
  property p_hs_nack;
    $rose(hs_mode) |-> !sda_oe && !scl_oe;
  endproperty
  property p_stop_fs;
    scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:8] !hs_mode;
  endproperty
  property p_ext_ref;
    reference_adjust_pin [*8] |=> !ref_power;
  endproperty
  property p_ref_early;
    ref_ready && ref_power |-> ref_cnt + 2 >= REF_SETTLE_CYC;
  endproperty
  property p_ref_late;
    ref_cnt >= REF_SETTLE_CYC + 4 |-> ref_ready;
  endproperty
  property p_track_two;
    $rose(conv_busy) |-> trk_rises == 2'h2;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock free in conversion");
  a_hold: assert property (p_hold) else $error("tracking in conversion");
  a_power: assert property (p_power) else $error("converting unpowered");
  a_release: assert property (p_release) else $error("release not to send");
  a_data_low: assert property (p_data_low) else $error("data moved, clock high");
  a_ack_conv: assert property (p_ack_conv) else $error("no stretch after ack");
  a_hs_nack: assert property (p_hs_nack) else $error("code was acknowledged");
  a_stop_fs: assert property (p_stop_fs) else $error("fast mode kept on stop");
  a_ext_ref: assert property (p_ext_ref) else $error("reference on, external");
  a_ref_early: assert property (p_ref_early) else $error("ready too early");
  a_ref_late: assert property (p_ref_late) else $error("ready too late");
  a_track_two: assert property (p_track_two) else $error("tracking not two clocks");
  c_hs: cover property ($rose(hs_mode));
  c_stretch: cover property ($fell(scl_oe));
  c_ready: cover property ($rose(ref_ready));
endmodule : sac_twowire_slave_assertions

bind sac_twowire_slave sac_twowire_slave_assertions #(.REF_SETTLE_CYC(REF_SETTLE_CYC))
  sac_chk_inst (.clk_sys, .rst_n, .scl_in, .sda_in, .scl_oe, .sda_oe,
  .reference_adjust_pin, .track, .analog_power, .ref_power, .ref_ready,
  .hs_mode, .conv_busy, .bus_state);

// ### tb/sac_master_model.sv
// Behavioural two-wire bus master facing the converter.
// Assumes pull-ups: a line reads high unless some party pulls it low.
`timescale 1ns/100ps
module sac_master_model #(
  parameter int H = 10
) (
  input wire logic clk_sys,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_drv
);
  int stalls;
  ////////////////////////
  // Both lines released at rest
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    stalls = 0;
  end
  // Start or repeated start: data falls while the clock is high
  task bus_start;
    @(posedge clk_sys);
    sda_drv <= 1'b1;
    repeat (H) @(posedge clk_sys);
    scl_drv <= 1'b1;
    repeat (H) @(posedge clk_sys);
    sda_drv <= 1'b0;
    repeat (H) @(posedge clk_sys);
    scl_drv <= 1'b0;
  endtask : bus_start
  // Stop: data rises while the clock is high, then the bus rests
  task bus_stop;
    @(posedge clk_sys);
    sda_drv <= 1'b0;
    repeat (H) @(posedge clk_sys);
    scl_drv <= 1'b1;
    repeat (H) @(posedge clk_sys);
    sda_drv <= 1'b1;
    repeat (H) @(posedge clk_sys);
  endtask : bus_stop
  // One clock; data moves only a cycle after the fall
  task bus_bit(input logic b, output logic r);
    int k;
    @(posedge clk_sys);
    sda_drv <= b;
    repeat (H) @(posedge clk_sys);
    scl_drv <= 1'b1;
    k = 0;
    // The slave may stretch; the wait is bounded so a stuck line is caught
    while (scl_line !== 1'b1 && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 400) stalls++;
    repeat (H) @(posedge clk_sys);
    r = sda_line;
    scl_drv <= 1'b0;
  endtask : bus_bit
  // Eight bits then the ninth slot, level a driven there
  task xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic n);
    for (int i = 7; i >= 0; i--) begin
      bus_bit(d[i], q[i]);
    end
    bus_bit(a, n);
  endtask : xfer
endmodule : sac_master_model

// ### tb/tb_top.sv
// Self-checking bench for the converter's two-wire front end.
// Assumes an ideal comparator: the kept code equals the analog value.
`timescale 1ns/100ps
module tb_top;
  import sac_pkg::*;
  logic clk_sys = 1'b0;
  logic clk_conv = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] sel = 4'ha;
  logic ref_ext = 1'b0;
  logic [15:0] analog_input_pin = 16'h0000;
  logic scl_drv, sda_drv, scl_oe, sda_oe, track, analog_power;
  logic ref_power, ref_ready, hs_mode, conv_busy;
  logic [15:0] dac_code;
  sac_state_t bus_state;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  // Open-drain lines with pull-ups
  wire scl_in = scl_drv & ~scl_oe;
  wire sda_in = sda_drv & ~sda_oe;
  wire cmp_in = (analog_input_pin >= dac_code);
  ////////////////////////
  // Clocks, the conversion one offset in phase
  always #20 clk_sys = ~clk_sys;
  initial begin
    #1.7;
    forever #3 clk_conv = ~clk_conv;
  end
  sac_twowire_slave #(.REF_SETTLE_CYC(50)) sac_twowire_slave_inst (
    .clk_sys, .rst_n, .clk_conv, .scl_in, .scl_out(), .scl_oe, .sda_in,
    .sda_out(), .sda_oe, .address_select_bit_zero(sel[0]),
    .address_select_bit_one(sel[1]), .address_select_bit_two(sel[2]),
    .address_select_bit_three(sel[3]), .reference_adjust_pin(ref_ext), .cmp_in,
    .dac_code, .track, .analog_power, .ref_power, .ref_ready, .hs_mode,
    .conv_busy, .bus_state);
  sac_master_model #(.H(10)) sac_master_model_inst (
    .clk_sys, .scl_line(scl_in), .sda_line(sda_in), .scl_drv, .sda_drv);
  ////////////////////////
  // Shorthands for the master's bus actions
  task bs;
    sac_master_model_inst.bus_start();
  endtask : bs
  task bp;
    sac_master_model_inst.bus_stop();
  endtask : bp
  task bx(input logic [7:0] d, input logic a, output logic [7:0] q, output logic n);
    sac_master_model_inst.xfer(d, a, q, n);
  endtask : bx
  task chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk16
  // Address the device and read one result; last is the final slot level
  task conv(input logic rw, input logic last, output logic n, output logic [15:0] v);
    logic [7:0] hi, lo;
    logic m;
    bs();
    bx({ADDR_FIXED, sel, rw}, 1'b1, hi, n);
    if (n === 1'b0) begin
      bx(8'hff, 1'b0, hi, m);
      bx(8'hff, last, lo, m);
    end
    v = {hi, lo};
  endtask : conv
  task complete_run;
    n_errors += sac_master_model_inst.stalls;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  ////////////////////////
  task t_reset;
    @(negedge clk_sys);
    chk1(analog_power, 1'b0);
    chk1(ref_power, 1'b0);
    chk1(hs_mode, 1'b0);
    chk1(track, 1'b0);
    chk1(sda_oe | scl_oe, 1'b0);
    $display("t_reset done");
  endtask : t_reset
  task t_single;
    logic n;
    logic [15:0] v;
    analog_input_pin <= 16'hb5c3;
    conv(1'b1, 1'b1, n, v);
    bp();
    @(negedge clk_sys);
    chk1(n, 1'b0);
    chk16(v, 16'hb5c3);
    chk1(analog_power, 1'b0);
    chk1(ref_power, 1'b1);
    chk1(ref_ready, 1'b1);
    $display("t_single done");
  endtask : t_single
  // Master keeps acknowledging; input moves while the first result waits
  task t_cont;
    logic n, m;
    logic [7:0] h1, l1, h2, l2;
    analog_input_pin <= 16'h0001;
    bs();
    bx({ADDR_FIXED, sel, 1'b1}, 1'b1, h1, n);
    bx(8'hff, 1'b0, h1, m);
    analog_input_pin <= 16'hfffe;
    bx(8'hff, 1'b0, l1, m);
    bx(8'hff, 1'b0, h2, m);
    bx(8'hff, 1'b1, l2, m);
    bp();
    @(negedge clk_sys);
    chk16({h1, l1}, 16'h0001);
    chk16({h2, l2}, 16'hfffe);
    $display("t_cont done");
  endtask : t_cont
  task t_foreign;
    logic n, m;
    logic [7:0] h;
    logic [15:0] v;
    bs();
    bx({ADDR_FIXED, ~sel, 1'b1}, 1'b1, h, n);
    chk1(n, 1'b1);
    bx(8'hff, 1'b1, h, m);
    chk16({8'h00, h}, 16'h00ff);
    chk1(analog_power, 1'b0);
    bp();
    conv(1'b1, 1'b1, n, v);
    bp();
    chk16(v, analog_input_pin);
    $display("t_foreign done");
  endtask : t_foreign
  // Every master code, then a repeated start in fast timing
  task t_hs;
    logic n;
    logic [7:0] h;
    logic [15:0] v;
    for (int c = 8; c < 16; c++) begin
      bs();
      bx(c[7:0], 1'b1, h, n);
      repeat (8) @(negedge clk_sys);
      chk1(n, 1'b1);
      chk1(hs_mode, 1'b1);
      bp();
      @(negedge clk_sys);
      chk1(hs_mode, 1'b0);
    end
    bs();
    bx(8'h0e, 1'b1, h, n);
    conv(1'b1, 1'b1, n, v);
    @(negedge clk_sys);
    chk1(hs_mode, 1'b1);
    chk16(v, analog_input_pin);
    bp();
    $display("t_hs done");
  endtask : t_hs
  task t_ref;
    logic n;
    logic [15:0] v;
    analog_input_pin <= 16'h8000;
    conv(1'b0, 1'b1, n, v);
    bp();
    @(negedge clk_sys);
    chk16(v, 16'h8000);
    chk1(ref_power, 1'b0);
    @(posedge clk_sys) ref_ext <= 1'b1;
    conv(1'b1, 1'b1, n, v);
    bp();
    @(negedge clk_sys);
    chk1(n, 1'b0);
    chk1(ref_power, 1'b0);
    @(posedge clk_sys) ref_ext <= 1'b0;
    $display("t_ref done");
  endtask : t_ref
  ////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_single();
    t_cont();
    t_foreign();
    t_hs();
    t_ref();
    complete_run();
  end
  // Hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      complete_run();
    end
  end
endmodule : tb_top
